/* File: core/aux_measurement_scheduler.v */
`timescale 1ns/1ps
`include "aux_meas_regs.vh"

module aux_measurement_scheduler (
  input wire ref_clk_i, // 100 MHz system clock
  input wire rst_i, // Synchronous reset, active high
  input wire ce_i, // Clock enable, freezes all state when low
  input wire [7:0] sfr_addr_i, // Register address
  input wire sfr_wr_i, // Register write strobe
  input wire sfr_rd_i, // Register read strobe
  input wire [7:0] sfr_wdata_i, // Register write data
  output reg [7:0] sfr_rdata_o, // Register read data
  input wire minute_tick_i, // One-minute tick from the time base
  input wire low_power_mode_one_i, // Device in first low-power mode
  input wire low_power_mode_two_i, // Device in second low-power mode
  input wire clock_keepalive_bit_i, // Keepalive bit of clock_config_register
  output reg conv_req_o, // Conversion request to converter
  output reg [1:0] conv_kind_o, // Kind of requested conversion
  input wire conv_ack_i, // Converter accepted the request
  input wire adc_done_i, // Conversion finished, result valid
  input wire [1:0] adc_kind_i, // Kind of the finished conversion
  input wire [7:0] adc_data_i, // Conversion result
  output reg thermal_irq_o, // Thermal delta event pulse
  output reg supply_irq_o, // Supply delta event pulse
  output reg battery_irq_o // Low battery event pulse
);

  // Configuration registers
  reg [7:0] strobe_period_config_r; // Period fields
  reg [7:0] delta_threshold_config_r; // Delta fields
  reg [7:0] battery_threshold_r; // Battery comparison level
  reg [2:0] start_r; // Software start bits
  reg [2:0] start_nxt; // Next start bits
  // Result registers
  reg [7:0] temperature_result_r; // Last thermal result
  reg [7:0] battery_result_r; // Last battery result
  reg [7:0] supply_result_r; // Last supply result
  // Values that last raised a delta interrupt
  reg [7:0] thermal_ref_r; // Thermal reference
  reg [7:0] supply_ref_r; // Supply reference
  // Background requests waiting for the converter
  reg [2:0] bg_pend_r; // Pending background bits
  reg [2:0] bg_pend_nxt; // Next pending bits
  reg [7:0] rdata_nxt; // Read mux output
  reg [1:0] pick_kind; // Kind chosen by arbiter
  reg pick_valid; // Any request waiting

  wire run_en; // Measurements allowed now
  wire [2:0] due; // Background due pulses
  wire [2:0] want; // Combined pending requests
  wire [2:0] acc_bit; // One-hot accepted kind
  wire [2:0] thermal_code; // Thermal delta field
  wire [2:0] supply_code; // Supply delta field
  wire wr_start; // Write to start register
  wire [7:0] start_wr_bits; // Write data limited to the start bits

  // Measurements stop in low power unless the keepalive bit is set
  assign run_en = !(low_power_mode_one_i || low_power_mode_two_i) || clock_keepalive_bit_i;
  // Software start bits and background due bits share the arbiter
  assign want = start_r | bg_pend_r;
  // Delta fields of the threshold register
  assign thermal_code = delta_threshold_config_r[`THERMAL_DELTA_POS+2:`THERMAL_DELTA_POS];
  assign supply_code = delta_threshold_config_r[`SUPPLY_DELTA_POS+2:`SUPPLY_DELTA_POS];
  // Start register write decode; only the three start bits are kept
  assign wr_start = sfr_wr_i && (sfr_addr_i == `ADDR_CONVERSION_START);
  assign start_wr_bits = sfr_wdata_i & `CONVERSION_START_MASK;
  // A raised request is taken on the edge where the converter accepts it
  assign acc_bit = (conv_req_o && conv_ack_i) ? kind_onehot(conv_kind_o) : 3'h0;

  // Kind code to one-hot bit, matching start bit positions
  function [2:0] kind_onehot;
    input [1:0] kind;
    begin
      case (kind)
        `KIND_SUPPLY: kind_onehot = 3'h1 << `SUPPLY_START_BIT;
        `KIND_THERMAL: kind_onehot = 3'h1 << `THERMAL_START_BIT;
        default: kind_onehot = 3'h1 << `BATTERY_START_BIT;
      endcase
    end
  endfunction

  // Absolute difference of two results
  function [7:0] abs_diff;
    input [7:0] a;
    input [7:0] b;
    begin
      if (a >= b) begin
        abs_diff = a - b;
      end else begin
        abs_diff = b - a;
      end
    end
  endfunction

  // Thermal delta code to minimum result difference
  function [7:0] thermal_thr;
    input [2:0] code;
    begin
      case (code)
        3'h1, 3'h2: thermal_thr = 8'h00; // Below one step: any reading
        3'h3, 3'h4: thermal_thr = 8'h01; // One step
        3'h5, 3'h6: thermal_thr = 8'h02; // Two steps
        // Unlisted codes between steps take the step of the code below
        default: thermal_thr = 8'h00; // Every reading
      endcase
    end
  endfunction

  // Supply delta code to minimum result difference
  function [7:0] supply_thr;
    input [2:0] code;
    begin
      case (code)
        3'h1, 3'h2, 3'h3: supply_thr = 8'h00; // Below one step: any reading
        3'h4, 3'h5, 3'h6: supply_thr = 8'h01; // One step
        // Unlisted codes between steps take the step of the code below
        default: supply_thr = 8'h00; // Every reading
      endcase
    end
  endfunction

  // Background scheduler
  // Only the six period bits pass; the minute count lives in the divider
  minute_divider u_minute_divider (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(run_en),
    .tick_i(minute_tick_i),
    .period_cfg_i(strobe_period_config_r[5:0]),
    .due_o(due)
  );

  // Arbiter: supply first, then thermal, then battery
  // Each accepted kind drops out of want, letting the next kind through
  always @* begin
    pick_valid = 1'b1;
    pick_kind = `KIND_BATTERY;
    if (want[`SUPPLY_START_BIT]) begin
      pick_kind = `KIND_SUPPLY;
    end else if (want[`THERMAL_START_BIT]) begin
      pick_kind = `KIND_THERMAL;
    end else if (want[`BATTERY_START_BIT]) begin
      pick_kind = `KIND_BATTERY;
    end else begin
      pick_valid = 1'b0;
    end
  end

  // Start and pending bits: a new request in the accept cycle survives
  // Pending bits are kept through low power until a request may be raised
  always @* begin
    start_nxt = start_r & ~acc_bit;
    if (wr_start) begin
      start_nxt = start_nxt | start_wr_bits[2:0]; // Set wins over accept
    end
    bg_pend_nxt = (bg_pend_r & ~acc_bit) | due;
  end

  // Converter request handshake; request held until accepted
  // Kind is loaded only with a new request, so it stands until accepted
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      conv_req_o <= 1'b0;
      conv_kind_o <= `KIND_BATTERY;
    end else if (ce_i) begin
      if (conv_req_o && conv_ack_i) begin
        conv_req_o <= 1'b0;
      end else if (!conv_req_o && pick_valid && run_en) begin
        conv_req_o <= 1'b1;
        conv_kind_o <= pick_kind;
      end
    end
  end

  // Request bookkeeping
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      start_r <= 3'h0;
      bg_pend_r <= 3'h0;
    end else if (ce_i) begin
      start_r <= start_nxt;
      bg_pend_r <= bg_pend_nxt;
    end
  end

  // Software configuration registers; reserved bits stay zero
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      strobe_period_config_r <= `RESET_CONFIG;
      delta_threshold_config_r <= `RESET_CONFIG;
      battery_threshold_r <= `RESET_CONFIG;
    end else if (ce_i && sfr_wr_i) begin
      if (sfr_addr_i == `ADDR_STROBE_PERIOD_CONFIG) begin
        strobe_period_config_r <= sfr_wdata_i & `STROBE_PERIOD_MASK;
      end else if (sfr_addr_i == `ADDR_DELTA_THRESHOLD_CONFIG) begin
        delta_threshold_config_r <= sfr_wdata_i & `DELTA_CONFIG_MASK;
      end else if (sfr_addr_i == `ADDR_BATTERY_THRESHOLD) begin
        battery_threshold_r <= sfr_wdata_i;
      end
    end
  end

  // Result registers: completion wins over a software write
  // Each result register follows only completions of its own kind
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      temperature_result_r <= `RESET_RESULT;
      battery_result_r <= `RESET_RESULT;
      supply_result_r <= `RESET_RESULT;
    end else if (ce_i) begin
      if (adc_done_i && adc_kind_i == `KIND_THERMAL) begin
        temperature_result_r <= adc_data_i;
      end else if (sfr_wr_i && sfr_addr_i == `ADDR_TEMPERATURE_RESULT) begin
        temperature_result_r <= sfr_wdata_i;
      end
      if (adc_done_i && adc_kind_i == `KIND_BATTERY) begin
        battery_result_r <= adc_data_i;
      end else if (sfr_wr_i && sfr_addr_i == `ADDR_BATTERY_RESULT) begin
        battery_result_r <= sfr_wdata_i;
      end
      if (adc_done_i && adc_kind_i == `KIND_SUPPLY) begin
        supply_result_r <= adc_data_i;
      end else if (sfr_wr_i && sfr_addr_i == `ADDR_SUPPLY_RESULT) begin
        supply_result_r <= sfr_wdata_i;
      end
    end
  end

  // Event detection on each completed conversion
  // Events are one-cycle pulses, cleared on every enabled edge
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      thermal_irq_o <= 1'b0;
      supply_irq_o <= 1'b0;
      battery_irq_o <= 1'b0;
      thermal_ref_r <= `RESET_RESULT;
      supply_ref_r <= `RESET_RESULT;
    end else if (ce_i) begin
      thermal_irq_o <= 1'b0;
      supply_irq_o <= 1'b0;
      battery_irq_o <= 1'b0;
      // Thermal reference moves only when an event fires
      if (adc_done_i && adc_kind_i == `KIND_THERMAL && thermal_code != `DELTA_OFF &&
          abs_diff(adc_data_i, thermal_ref_r) >= thermal_thr(thermal_code)) begin
        thermal_irq_o <= 1'b1;
        thermal_ref_r <= adc_data_i;
      end
      // Supply uses the same scheme with its own field and reference
      if (adc_done_i && adc_kind_i == `KIND_SUPPLY && supply_code != `DELTA_OFF &&
          abs_diff(adc_data_i, supply_ref_r) >= supply_thr(supply_code)) begin
        supply_irq_o <= 1'b1;
        supply_ref_r <= adc_data_i;
      end
      // Battery is a plain comparison, no reference kept
      if (adc_done_i && adc_kind_i == `KIND_BATTERY && adc_data_i < battery_threshold_r) begin
        battery_irq_o <= 1'b1;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_nxt = 8'h00;
    if (sfr_addr_i == `ADDR_TEMPERATURE_RESULT) begin
      rdata_nxt = temperature_result_r;
    end else if (sfr_addr_i == `ADDR_CONVERSION_START) begin
      rdata_nxt = {5'h00, start_r};
    end else if (sfr_addr_i == `ADDR_BATTERY_RESULT) begin
      rdata_nxt = battery_result_r;
    end else if (sfr_addr_i == `ADDR_SUPPLY_RESULT) begin
      rdata_nxt = supply_result_r;
    end else if (sfr_addr_i == `ADDR_DELTA_THRESHOLD_CONFIG) begin
      rdata_nxt = delta_threshold_config_r;
    end else if (sfr_addr_i == `ADDR_STROBE_PERIOD_CONFIG) begin
      rdata_nxt = strobe_period_config_r;
    end else if (sfr_addr_i == `ADDR_BATTERY_THRESHOLD) begin
      rdata_nxt = battery_threshold_r;
    end
  end

  // Read data captured on the read strobe
  // Data holds between reads, so software may look at it late
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (ce_i && sfr_rd_i) begin
      sfr_rdata_o <= rdata_nxt;
    end
  end

endmodule // aux_measurement_scheduler

/* File: core/aux_meas_regs.vh */
`ifndef AUX_MEAS_REGS_VH
`define AUX_MEAS_REGS_VH

// Register addresses on the special function register bus
`define ADDR_TEMPERATURE_RESULT 8'hd7
`define ADDR_CONVERSION_START 8'hd8
`define ADDR_BATTERY_RESULT 8'hdf
`define ADDR_SUPPLY_RESULT 8'hef
`define ADDR_DELTA_THRESHOLD_CONFIG 8'hf3
`define ADDR_STROBE_PERIOD_CONFIG 8'hf9
`define ADDR_BATTERY_THRESHOLD 8'hfa

// Strobe period field positions (low bit of each two-bit field)
`define SUPPLY_PERIOD_POS 4
`define BATTERY_PERIOD_POS 2
`define THERMAL_PERIOD_POS 0
// Writable bits of the strobe period register
`define STROBE_PERIOD_MASK 8'h3f

// Delta field positions (low bit of each three-bit field)
`define THERMAL_DELTA_POS 3
`define SUPPLY_DELTA_POS 0
`define DELTA_CONFIG_MASK 8'h3f

// Start bits in the conversion start register
`define SUPPLY_START_BIT 2
`define THERMAL_START_BIT 1
`define BATTERY_START_BIT 0
`define CONVERSION_START_MASK 8'h07

// Measurement kind codes on the converter port
`define KIND_BATTERY 2'h0
`define KIND_THERMAL 2'h1
`define KIND_SUPPLY 2'h2

// Reset values
`define RESET_CONFIG 8'h00
`define RESET_RESULT 8'h00

// Period codes
`define PERIOD_OFF 2'h0
`define PERIOD_LONG 2'h1
`define PERIOD_MID 2'h2
`define PERIOD_EVERY 2'h3

// Minute-count masks: a conversion is due when the masked count is all ones
`define MASK_8_MIN 4'h7
`define MASK_16_MIN 4'hf
`define MASK_2_MIN 4'h1
`define MASK_4_MIN 4'h3
`define MASK_1_MIN 4'h0

// Delta codes
`define DELTA_OFF 3'h0
`define DELTA_EVERY 3'h7

`endif

/* File: core/minute_divider.v */
`timescale 1ns/1ps
`include "aux_meas_regs.vh"

// Turns the minute tick into background conversion due pulses
module minute_divider (
  input wire ref_clk_i, // System clock
  input wire rst_i, // Synchronous reset, active high
  input wire ce_i, // Clock enable
  input wire run_i, // Measurements allowed
  input wire tick_i, // One-minute tick from the time base
  input wire [5:0] period_cfg_i, // Strobe period fields
  output reg [2:0] due_o // Due pulse per kind: supply, thermal, battery
);

  reg [3:0] minute_r; // Minutes elapsed, wraps at sixteen
  reg [3:0] minute_nxt; // Next minute count

  // Mask selecting the period for a code; the battery field uses the longer set
  function [3:0] period_mask;
    input [1:0] code;
    input is_battery;
    begin
      case (code)
        `PERIOD_LONG: period_mask = is_battery ? `MASK_16_MIN : `MASK_8_MIN;
        `PERIOD_MID: period_mask = is_battery ? `MASK_4_MIN : `MASK_2_MIN;
        default: period_mask = `MASK_1_MIN;
      endcase
    end
  endfunction

  // Minute counter advances only while measurements may run
  always @* begin
    minute_nxt = minute_r;
    if (run_i && tick_i) begin
      minute_nxt = minute_r + 4'h1;
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      minute_r <= 4'h0;
    end else if (ce_i) begin
      minute_r <= minute_nxt;
    end
  end

  wire [2:0] due_nxt; // Due decision per kind, one bit each

  // One due decoder per measurement kind
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_due
      localparam integer POS = (k == 2) ? `SUPPLY_PERIOD_POS :
                               (k == 1) ? `THERMAL_PERIOD_POS : `BATTERY_PERIOD_POS;
      wire [1:0] code = period_cfg_i[POS+1:POS]; // Field for this kind
      wire [3:0] mask = period_mask(code, k == 0); // Period mask
      // Code zero never schedules a conversion
      assign due_nxt[k] = run_i && tick_i && (code != `PERIOD_OFF) && ((minute_r & mask) == mask);
    end
  endgenerate

  // Due pulses registered in one process, so each bit has a single driver
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      due_o <= 3'h0;
    end else if (ce_i) begin
      due_o <= due_nxt;
    end
  end

endmodule // minute_divider

/* File: testbench/aux_meas_assertions.sv */
`timescale 1ns/1ps
// Port-level timing checks for the measurement scheduler
module aux_meas_checker (
  input wire ref_clk_i, // Clock
  input wire rst_i, // Reset
  input wire ce_i, // Enable
  input wire [7:0] sfr_addr_i, // Address
  input wire sfr_wr_i, // Write
  input wire sfr_rd_i, // Read
  input wire [7:0] sfr_wdata_i, // Write data
  input wire [7:0] sfr_rdata_o, // Read data
  input wire minute_tick_i, // Tick
  input wire low_power_mode_one_i, // Mode one
  input wire low_power_mode_two_i, // Mode two
  input wire clock_keepalive_bit_i, // Keepalive
  input wire conv_req_o, // Request
  input wire [1:0] conv_kind_o, // Request kind
  input wire conv_ack_i, // Accept
  input wire adc_done_i, // Done
  input wire [1:0] adc_kind_i, // Done kind
  input wire [7:0] adc_data_i, // Result
  input wire thermal_irq_o, // Thermal event
  input wire supply_irq_o, // Supply event
  input wire battery_irq_o // Battery event
);
  // Address hits one of the seven registers
  wire mapped = sfr_addr_i == 8'hd7 || sfr_addr_i == 8'hd8 || sfr_addr_i == 8'hdf || sfr_addr_i == 8'hef ||
    sfr_addr_i == 8'hf3 || sfr_addr_i == 8'hf9 || sfr_addr_i == 8'hfa;
  // Low power without keepalive holds off new requests
  wire blocked = (low_power_mode_one_i || low_power_mode_two_i) && !clock_keepalive_bit_i;
  // Completed conversions of each kind, as the design samples them
  wire battery_done = ce_i && adc_done_i && adc_kind_i == 2'h0;
  wire thermal_done = ce_i && adc_done_i && adc_kind_i == 2'h1;
  wire supply_done = ce_i && adc_done_i && adc_kind_i == 2'h2;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  a_req_hold: assert property (conv_req_o && !conv_ack_i && ce_i |=> conv_req_o && $stable(conv_kind_o))
    else $error("request or kind changed before accept");
  a_req_drop: assert property (conv_req_o && conv_ack_i && ce_i |=> !conv_req_o)
    else $error("request stayed up after accept");
  a_lowpower_block: assert property (blocked && !conv_req_o && ce_i |=> !conv_req_o)
    else $error("request started while held off");
  a_battery_cause: assert property (battery_irq_o |-> $past(battery_done))
    else $error("battery event without battery result");
  a_thermal_cause: assert property (thermal_irq_o |-> $past(thermal_done))
    else $error("thermal event without thermal result");
  a_supply_cause: assert property (supply_irq_o |-> $past(supply_done))
    else $error("supply event without supply result");
  a_read_hold: assert property (ce_i && !sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (ce_i && sfr_rd_i && !mapped |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i && ce_i |=>
    !conv_req_o && !thermal_irq_o && !supply_irq_o && !battery_irq_o && sfr_rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  c_accept: cover property (conv_req_o && conv_ack_i);
  c_thermal: cover property (thermal_irq_o);
  c_battery: cover property (battery_irq_o);
  c_supply: cover property (supply_irq_o);
endmodule // aux_meas_checker

bind aux_measurement_scheduler aux_meas_checker i_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .minute_tick_i(minute_tick_i),
  .low_power_mode_one_i(low_power_mode_one_i), .low_power_mode_two_i(low_power_mode_two_i),
  .clock_keepalive_bit_i(clock_keepalive_bit_i), .conv_req_o(conv_req_o), .conv_kind_o(conv_kind_o),
  .conv_ack_i(conv_ack_i), .adc_done_i(adc_done_i), .adc_kind_i(adc_kind_i), .adc_data_i(adc_data_i),
  .thermal_irq_o(thermal_irq_o), .supply_irq_o(supply_irq_o), .battery_irq_o(battery_irq_o)
);

/* File: testbench/aux_measurement_scheduler_tb.sv */
`timescale 1ns/1ps
`include "aux_meas_regs.vh"
// Self-checking bench for the measurement scheduler
module aux_measurement_scheduler_tb;
  reg ref_clk_i = 1'b0; // Clock
  reg rst_i = 1'b1; // Reset
  reg ce = 1'b1; // Clock enable
  reg [7:0] addr = 8'h00; // Register address
  reg wr_s = 1'b0; // Write strobe
  reg rd_s = 1'b0; // Read strobe
  reg [7:0] wdata = 8'h00; // Write data
  reg tick = 1'b0; // Minute tick
  reg lp_one = 1'b0; // Mode one
  reg lp_two = 1'b0; // Mode two
  reg keep = 1'b0; // Keepalive
  reg ack = 1'b0; // Converter accept
  reg done_s = 1'b0; // Result valid
  reg [1:0] kind = 2'h0; // Result kind
  reg [7:0] data = 8'h00; // Result value
  wire [7:0] rdata; // Read data
  wire req; // Request
  wire [1:0] req_kind; // Request kind
  wire [2:0] irq; // Events: supply, thermal, battery
  integer miscompares = 0; // Mismatch count
  integer tests_run = 0; // Comparison count
  integer i, p; // Loop indices
  reg [7:0] rv, pc; // Read value, period setting
  reg [2:0] seen, ev; // Kinds requested, events seen
  reg [5:0] seq; // Request order
  reg [23:0] r; // Current row
  // Rows: delta cfg, kind, result, expected events
  reg [23:0] rows [0:17] = '{24'h1f0410, 24'h1f0400, 24'h1f03f1, 24'h1f1000, 24'h1f1012, 24'h1f2004,
    24'h281020, 24'h281032, 24'h282550, 24'h081032, 24'h0017f0, 24'h242000, 24'h242014,
    24'h381032, 24'h301040, 24'h301052, 24'h101052, 24'h092014};
  reg [63:0] addrs = {8'hd7, 8'hd8, 8'hdf, 8'hef, 8'hf3, 8'hf9, 8'hfa, 8'h00}; // All places
  reg [31:0] cfgs = {8'h00, 8'h16, 8'h3b, 8'h2d}; // Period settings
  always #5 ref_clk_i = ~ref_clk_i; // 100 MHz
  aux_measurement_scheduler i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .sfr_addr_i(addr), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .minute_tick_i(tick), .low_power_mode_one_i(lp_one),
    .low_power_mode_two_i(lp_two), .clock_keepalive_bit_i(keep), .conv_req_o(req), .conv_kind_o(req_kind),
    .conv_ack_i(ack), .adc_done_i(done_s), .adc_kind_i(kind), .adc_data_i(data),
    .thermal_irq_o(irq[1]), .supply_irq_o(irq[2]), .battery_irq_o(irq[0])
  );
  // Compare one value
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got); begin
    tests_run = tests_run + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
    end
  end endtask
  // Register write, one cycle strobe
  task wr(input [7:0] a, input [7:0] d); begin
    @(negedge ref_clk_i);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge ref_clk_i);
    wr_s = 1'b0;
  end endtask
  // Register read, data one cycle after the strobe
  task rd(input [7:0] a, output [7:0] d); begin
    @(negedge ref_clk_i);
    addr = a;
    rd_s = 1'b1;
    @(negedge ref_clk_i);
    rd_s = 1'b0;
    d = rdata;
  end endtask
  // Accept every request for n cycles, noting kinds and order
  task serve(input integer n); begin
    seen = 3'h0;
    seq = 6'h00;
    repeat (n) begin
      @(negedge ref_clk_i);
      ack = req === 1'b1;
      if (ack) begin
        seen[req_kind] = 1'b1;
        seq = {seq[3:0], req_kind};
      end
    end
    @(negedge ref_clk_i);
    ack = 1'b0;
  end endtask
  // Deliver one result and collect the events it gives
  task done(input [1:0] k, input [7:0] d); begin
    @(negedge ref_clk_i);
    kind = k;
    data = d;
    done_s = 1'b1;
    @(negedge ref_clk_i);
    done_s = 1'b0;
    ev = irq;
    @(negedge ref_clk_i);
    ev = ev | irq;
  end endtask
  // Background conversion due on a tick at minute count c
  function due(input [1:0] code, input b, input [3:0] c);
    reg [3:0] m; begin
    m = code == `PERIOD_LONG ? (b ? 4'hf : 4'h7) : code == `PERIOD_MID ? (b ? 4'h3 : 4'h1) : 4'h0;
    due = code != `PERIOD_OFF && (c & m) == m;
  end endfunction
  // Result register of a kind
  function [7:0] res_addr(input [1:0] k);
    res_addr = k == `KIND_BATTERY ? `ADDR_BATTERY_RESULT :
      k == `KIND_THERMAL ? `ADDR_TEMPERATURE_RESULT : `ADDR_SUPPLY_RESULT;
  endfunction
  // Verdict
  task conclude; begin
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  end endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      rd(addrs[i*8 +: 8], rv);
      chk("reset", 8'h00, rv);
    end
    wr(`ADDR_BATTERY_THRESHOLD, 8'h40);
    for (i = 0; i < 18; i = i + 1) begin
      r = rows[i];
      wr(`ADDR_DELTA_THRESHOLD_CONFIG, r[23:16]);
      done(r[13:12], r[11:4]);
      chk("events", {5'h00, r[2:0]}, {5'h00, ev});
      rd(res_addr(r[13:12]), rv);
      chk("result", r[11:4], rv);
    end
    // Reserved bits, plain storage and unmapped writes
    wr(`ADDR_STROBE_PERIOD_CONFIG, 8'hff);
    rd(`ADDR_STROBE_PERIOD_CONFIG, rv);
    chk("period", 8'h3f, rv);
    wr(`ADDR_DELTA_THRESHOLD_CONFIG, 8'hff);
    rd(`ADDR_DELTA_THRESHOLD_CONFIG, rv);
    chk("delta", 8'h3f, rv);
    wr(8'h01, 8'hff);
    rd(8'h01, rv);
    chk("unmapped", 8'h00, rv);
    // Clock enable low: a write is ignored, the old threshold stays
    ce = 1'b0;
    wr(`ADDR_BATTERY_THRESHOLD, 8'h11);
    ce = 1'b1;
    rd(`ADDR_BATTERY_THRESHOLD, rv);
    chk("freeze", 8'h40, rv);
    // All three start bits at once: priority order, then cleared
    wr(`ADDR_CONVERSION_START, 8'hff);
    rd(`ADDR_CONVERSION_START, rv);
    chk("start", 8'h07, rv);
    serve(20);
    chk("order", 8'h24, {2'h0, seq});
    rd(`ADDR_CONVERSION_START, rv);
    chk("cleared", 8'h00, rv);
    // Each low-power mode holds requests until keepalive is set
    for (p = 0; p < 2; p = p + 1) begin
      lp_one = p == 0;
      lp_two = p == 1;
      keep = 1'b0;
      wr(`ADDR_CONVERSION_START, 8'h02);
      serve(12);
      chk("held", 8'h00, {5'h00, seen});
      keep = 1'b1;
      serve(12);
      chk("kept", 8'h02, {5'h00, seen});
    end
    lp_one = 1'b0;
    lp_two = 1'b0;
    // Background schedule over every period code
    for (p = 0; p < 4; p = p + 1) begin
      pc = cfgs[p*8 +: 8];
      wr(`ADDR_STROBE_PERIOD_CONFIG, pc);
      for (i = 0; i < 16; i = i + 1) begin
        @(negedge ref_clk_i);
        tick = 1'b1;
        @(negedge ref_clk_i);
        tick = 1'b0;
        serve(20);
        chk("due", {5'h00, due(pc[5:4], 1'b0, i[3:0]), due(pc[1:0], 1'b0, i[3:0]),
          due(pc[3:2], 1'b1, i[3:0])}, {5'h00, seen});
      end
    end
    // Reset in mid-run clears a held start bit and every register
    lp_one = 1'b1;
    keep = 1'b0;
    wr(`ADDR_CONVERSION_START, 8'h01);
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    lp_one = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      rd(addrs[i*8 +: 8], rv);
      chk("rerun", 8'h00, rv);
    end
    serve(8);
    chk("flushed", 8'h00, {5'h00, seen});
    conclude;
  end
endmodule // aux_measurement_scheduler_tb
